// file: design/paged_address_translation_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "patu_params.svh"
module paged_address_translation_unit
    import patu_pkg::*;
(
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    // apb slave
    input  wire logic [7:0]       paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // emulator control
    input  wire logic             translation_disable_in,
    // core paths, index 0 fetch, 1 data
    input  wire logic [1:0]       xl_req,
    input  wire logic [1:0]       xl_super,
    input  wire logic [1:0]       xl_write,
    input  wire logic [1:0][31:0] xl_la,
    input  wire logic             xl_exec,
    output wire logic [1:0]       xl_ready,
    output wire logic [1:0]       xl_err,
    output wire logic [1:0][31:0] xl_pa,
    output wire logic [1:0][1:0]  xl_cm,
    output wire logic [1:0][1:0]  user_attribute_outputs,
    output logic                  exec_err,
    // descriptor bus
    output logic                  mem_req,
    output logic                  mem_we,
    output logic                  mem_nocache,
    output logic      [31:0]      mem_addr,
    output logic      [31:0]      mem_wdata,
    input  wire logic             mem_ack,
    input  wire logic             mem_terr,
    input  wire logic [31:0]      mem_rdata
);

    state_t    q;
    state_t    d;
    logic      p8;
    logic      off;
    wire [1:0] miss;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // page number, 8K pages drop bit 12
    function automatic logic [19:0] vpn_of(input logic [31:0] a, input logic big);
        vpn_of = big ? {1'b0, a[31:13]} : a[31:12];
    endfunction

    // transparent block match
    function automatic logic tt_hit(input logic [31:0] t, input logic [31:0] a,
                                    input logic su);
        logic sm_ok;
        sm_ok = t[`TT_SM+1] | (t[`TT_SM] == su);
        tt_hit = t[`TT_EN] & sm_ok & (((a[31:24] ^ t[31:24]) & ~t[23:16]) == 8'h00);
    endfunction

    // decoded register window
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) &&
                 (a <= `A_FADDR || (a >= `A_TT && a <= `A_TTEND));
    endfunction

    assign p8  = q.ctrl[`C_P8K];
    assign off = translation_disable_in | ~q.ctrl[`C_EN];

    // ----------------------------------------
    // per-path lookup
    // ----------------------------------------
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_path
            logic [19:0] vp;
            logic [3:0]  hw;
            logic        hit;
            logic        t0;
            logic        t1;
            logic        byp;
            logic        prot;
            entry_t      he;

            assign vp = vpn_of(xl_la[p], p8);
            // tags compared while the set is indexed
            for (genvar w = 0; w < 4; w++) begin : g_way
                assign hw[w] = q.tc[p][vp[3:0]][w].v &&
                               q.tc[p][vp[3:0]][w].tag == vp[19:4] &&
                               q.tc[p][vp[3:0]][w].su == xl_super[p];
            end
            always_comb begin
                he = '0;
                for (int w = 0; w < 4; w++) begin
                    if (hw[w]) begin
                        he = q.tc[p][vp[3:0]][w];
                    end
                end
            end
            assign hit = |hw;
            assign t0  = tt_hit(q.tt[2*p], xl_la[p], xl_super[p]);
            assign t1  = tt_hit(q.tt[2*p+1], xl_la[p], xl_super[p]);
            assign byp = off | t0 | t1;
            // protection checks
            assign prot = off ? 1'b0 :
                          t0 ? q.tt[2*p][`TT_WP] & xl_write[p] :
                          t1 ? q.tt[2*p+1][`TT_WP] & xl_write[p] :
                          hit & ((he.s & ~xl_super[p]) | (he.wp & xl_write[p]));
            // a miss holds the access until load or fault
            assign miss[p]     = xl_req[p] & ~byp & ~hit & ~q.wfault[p];
            assign xl_ready[p] = xl_req[p] & (byp | hit | q.wfault[p]);
            assign xl_err[p]   = xl_req[p] & (prot | q.wfault[p]);
            // address, mode and attribute selection
            assign xl_pa[p] = byp ? xl_la[p] :
                              p8 ? {he.pfn[19:1], xl_la[p][12:0]} :
                              {he.pfn, xl_la[p][11:0]};
            assign xl_cm[p] = off ? q.ctrl[`C_DCM +: 2] :
                              t0 ? q.tt[2*p][`TT_CM +: 2] :
                              t1 ? q.tt[2*p+1][`TT_CM +: 2] : he.cm;
            assign user_attribute_outputs[p] = off ? q.ctrl[`C_DUA +: 2] :
                              t0 ? q.tt[2*p][`TT_UA +: 2] :
                              t1 ? q.tt[2*p+1][`TT_UA +: 2] : he.ua;

            chk_super_prot: assert property (
                xl_req[p] && hit && !byp && he.s && !xl_super[p] |-> xl_err[p] && xl_ready[p]
            ) else $error("user access to supervisor page not refused");
            chk_ua_drive: assert property (
                xl_req[p] && hit && !byp |-> user_attribute_outputs[p] == he.ua &&
                                             xl_cm[p] == he.cm
            ) else $error("attribute outputs differ from entry");
            chk_stall_miss: assert property (
                miss[p] |-> !xl_ready[p] ##1 (q.st != W_IDLE || !miss[p] || q.path != p)
            ) else $error("missing access not stalled or walk not started");
        end
    endgenerate

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic        flt;
        logic [19:0] lv;
        flt  = 1'b0;
        lv   = vpn_of(q.la, p8);
        d    = q;
        d.wfault = 2'b00;
        // apb read data captured in setup phase
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `A_CTRL:  d.prdata = q.ctrl;
                `A_URP:   d.prdata = q.urp;
                `A_SRP:   d.prdata = q.srp;
                `A_FLUSH: d.prdata = 32'h0000_0000;
                `A_STAT:  d.prdata = {30'h0, q.sflt, q.st != W_IDLE};
                `A_FADDR: d.prdata = q.faddr;
                default:  d.prdata = mapped(paddr) ? q.tt[paddr[3:2]] : 32'h0000_0000;
            endcase
        end
        // apb writes in access phase
        if (psel && penable && pwrite && mapped(paddr)) begin
            case (paddr)
                `A_CTRL:  d.ctrl = pwdata;
                `A_URP:   d.urp  = pwdata;
                `A_SRP:   d.srp  = pwdata;
                `A_FLUSH: begin
                    for (int i = 0; i < 2; i++) begin
                        for (int s = 0; s < 16; s++) begin
                            for (int w = 0; w < 4; w++) begin
                                if (pwdata[`F_GO] &&
                                    (!pwdata[`F_NG] || !q.tc[i][s][w].g)) begin
                                    d.tc[i][s][w].v = 1'b0;
                                end
                            end
                        end
                    end
                end
                `A_STAT: begin
                    if (pwdata[`S_FLT]) begin
                        d.sflt = 1'b0;
                    end
                end
                `A_FADDR: d.faddr = q.faddr;
                default:  d.tt[paddr[3:2]] = pwdata;
            endcase
        end
        // fetch faults wait for execution
        if (xl_exec && q.ipend) begin
            d.ipend = 1'b0;
        end
        if (xl_ready[0] && xl_err[0]) begin
            d.ipend = 1'b1;
        end
        // table walker
        unique case (q.st)
            W_IDLE: begin
                if (miss[1] || miss[0]) begin
                    d.path = miss[1];
                    d.la   = xl_la[miss[1]];
                    d.su   = xl_super[miss[1]];
                    d.wr   = xl_write[miss[1]];
                    d.wp   = 1'b0;
                    d.lvl  = 2'h0;
                    d.addr = {(xl_super[miss[1]] ? q.srp[31:9] : q.urp[31:9]),
                              xl_la[miss[1]][31:25], 2'h0};
                    d.st   = W_FETCH;
                end
            end
            W_FETCH: begin
                if (mem_ack) begin
                    if (mem_terr) begin
                        flt = 1'b1;
                    end else begin
                        d.desc = mem_rdata;
                        d.st   = W_CHECK;
                    end
                end
            end
            W_HIST: begin
                if (mem_ack) begin
                    flt  = mem_terr;
                    d.st = W_CHECK;
                end
            end
            W_CHECK: begin
                if (q.lvl < 2'h2) begin
                    if (!q.desc[1]) begin
                        flt = 1'b1;
                    end else if (!q.desc[`D_U]) begin
                        d.desc[`D_U] = 1'b1;
                        d.st = W_HIST;
                    end else begin
                        d.wp  = q.wp | q.desc[`D_WP];
                        d.lvl = q.lvl + 2'h1;
                        d.st  = W_FETCH;
                        if (q.lvl == 2'h0) begin
                            d.addr = {q.desc[31:9], q.la[24:18], 2'h0};
                        end else if (p8) begin
                            d.addr = {q.desc[31:7], q.la[17:13], 2'h0};
                        end else begin
                            d.addr = {q.desc[31:8], q.la[17:12], 2'h0};
                        end
                    end
                end else if (q.desc[1:0] == `PDT_IND && q.lvl == 2'h2) begin
                    d.addr = {q.desc[31:2], 2'h0};
                    d.lvl  = 2'h3;
                    d.st   = W_FETCH;
                end else if (q.desc[1:0] == 2'h0 || q.desc[1:0] == `PDT_IND) begin
                    flt = 1'b1;
                end else if (!q.desc[`D_U] || (q.wr && !q.desc[`D_M])) begin
                    d.desc[`D_U] = 1'b1;
                    d.desc[`D_M] = q.desc[`D_M] | q.wr;
                    d.st = W_HIST;
                end else begin
                    // install the entry, the access then hits
                    d.tc[q.path][lv[3:0]][q.rr[q.path][lv[3:0]]] = '{
                        v: 1'b1, g: q.desc[`D_G], su: q.su, tag: lv[19:4],
                        pfn: q.desc[31:12], s: q.desc[`D_S],
                        wp: q.wp | q.desc[`D_WP],
                        cm: q.desc[`D_CM +: 2], ua: q.desc[`D_UA +: 2]};
                    d.rr[q.path][lv[3:0]] = q.rr[q.path][lv[3:0]] + 2'h1;
                    d.st = W_IDLE;
                end
            end
        endcase
        // fault ends the walk, set beats clear
        if (flt) begin
            d.wfault[q.path] = 1'b1;
            d.faddr = q.la;
            d.sflt  = 1'b1;
            d.st    = W_IDLE;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata      = q.prdata;
    assign pready      = 1'b1;
    assign pslverr     = psel & penable & ~mapped(paddr);
    assign exec_err    = q.ipend & xl_exec;
    assign mem_req     = (q.st == W_FETCH) | (q.st == W_HIST);
    assign mem_we      = q.st == W_HIST;
    assign mem_addr    = q.addr;
    assign mem_wdata   = q.desc;
    assign mem_nocache = 1'b1;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_disable_pass: assert property (
        translation_disable_in |-> xl_pa[0] == xl_la[0] && xl_pa[1] == xl_la[1] &&
                                   xl_cm[1] == q.ctrl[`C_DCM +: 2]
    ) else $error("translation active while disabled");
    // request, address and no-cache hold until the answer
    chk_nocache_walk: assert property (
        mem_req && !mem_ack |=> mem_req && mem_nocache && $stable(mem_addr)
    ) else $error("descriptor fetch dropped or may be cached");
    chk_hist_sets_used: assert property (
        mem_we |-> mem_wdata[`D_U] && mem_wdata[1:0] != 2'h0
    ) else $error("history write without used bit");
    chk_root_index: assert property (
        q.st == W_FETCH && q.lvl == 2'h0 |-> q.addr[8:2] == q.la[31:25] &&
            q.addr[31:9] == (q.su ? q.srp[31:9] : q.urp[31:9])
    ) else $error("root descriptor address wrong");
    chk_page8k_addr: assert property (
        $rose(q.st == W_FETCH && q.lvl == 2'h2) && p8 |->
            q.addr[6:2] == q.la[17:13] && q.addr[1:0] == 2'h0
    ) else $error("8K page descriptor address wrong");
    chk_page4k_addr: assert property (
        $rose(q.st == W_FETCH && q.lvl == 2'h2) && !p8 |-> q.addr[7:2] == q.la[17:12]
    ) else $error("4K page descriptor address wrong");
    chk_ind_fetch: assert property (
        q.st == W_CHECK && q.lvl == 2'h2 && q.desc[1:0] == `PDT_IND |=>
            q.st == W_FETCH && q.lvl == 2'h3 && q.addr[31:2] == $past(q.desc[31:2])
    ) else $error("indirect descriptor not followed");
    chk_fault_signal: assert property (
        q.st == W_CHECK && q.lvl < 2'h2 && !q.desc[1] |=>
            q.wfault[$past(q.path)] && q.st == W_IDLE && q.sflt
    ) else $error("invalid descriptor without access error");

endmodule
`default_nettype wire

// file: design/patu_params.svh
// Notes on behaviour
// - two paths, each 64-entry 4-way cache
// - 32-bit logical maps to 32-bit physical
// - page size selectable, 4 or 8 Kbytes
// - two-bit user extension travels with address
// - global flag survives non-global flush
// - supervisor and user roots are separate
// - two untranslated blocks per path
// - three-level walk, optional indirect page step
// - walker sets history bits in memory
// - disable input stops translation at once
// - cache lookup adds no latency
// - 8K: pointer[31:7], index times four
// - 4K: pointer[31:8], index times four
// - write protect gathered over all levels
// - walk loads entry, access then uses it
// - indirect page descriptor fetched once more
// - invalid descriptors allowed below root
// - invalid descriptor gives access error
// - caching mode comes from page entry
// - disabled translation uses default mode and attributes, blocks use their own
// - supervisor-only and write protection enforced
// - attribute outputs follow entry attribute bits
// - data errors immediate, fetch errors deferred
// - descriptor fetches never use data cache
`ifndef PATU_PARAMS_SVH
`define PATU_PARAMS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define A_CTRL  8'h00
`define A_URP   8'h04
`define A_SRP   8'h08
`define A_FLUSH 8'h0C
`define A_STAT  8'h10
`define A_FADDR 8'h14
`define A_TT    8'h20
`define A_TTEND 8'h2C
// ----------------------------------------
// field positions
// ----------------------------------------
`define C_EN   0
`define C_P8K  1
`define C_DCM  2
`define C_DUA  4
`define F_GO   0
`define F_NG   1
`define S_FLT  1
`define TT_EN  15
`define TT_SM  13
`define TT_UA  8
`define TT_CM  5
`define TT_WP  2
`define D_WP   2
`define D_U    3
`define D_M    4
`define D_CM   5
`define D_S    7
`define D_UA   8
`define D_G    10
`define PDT_IND 2'h2
`endif

// file: design/patu_pkg.sv
package patu_pkg;
    // one cached translation
    typedef struct packed {
        logic        v;
        logic        g;
        logic        su;
        logic [15:0] tag;
        logic [19:0] pfn;
        logic        s;
        logic        wp;
        logic [1:0]  cm;
        logic [1:0]  ua;
    } entry_t;
    typedef enum logic [1:0] {W_IDLE, W_FETCH, W_CHECK, W_HIST} walk_t;
    // whole block state
    typedef struct packed {
        entry_t [1:0][15:0][3:0] tc;
        logic [1:0][15:0][1:0]   rr;
        logic [31:0]             ctrl;
        logic [31:0]             urp;
        logic [31:0]             srp;
        logic [31:0]             faddr;
        logic [3:0][31:0]        tt;
        walk_t                   st;
        logic                    path;
        logic                    su;
        logic                    wr;
        logic                    wp;
        logic [1:0]              lvl;
        logic [31:0]             la;
        logic [31:0]             addr;
        logic [31:0]             desc;
        logic [1:0]              wfault;
        logic                    ipend;
        logic                    sflt;
        logic [31:0]             prdata;
    } state_t;
endpackage

// file: dv/paged_address_translation_unit_test.sv
`timescale 1ns/100ps
`default_nettype none
module paged_address_translation_unit_test;
    import patu_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic             clk_sys = 1'b0;
    logic             rst_b = 1'b0;
    logic [7:0]       paddr = 8'h00;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic [31:0]      pwdata = 32'h0;
    logic [31:0]      prdata;
    logic             pready, pslverr, exec_err;
    logic             translation_disable_in = 1'b0;
    logic [1:0]       xl_req = 2'h0;
    logic [1:0]       xl_super = 2'h0;
    logic [1:0]       xl_write = 2'h0;
    logic [1:0][31:0] xl_la = '0;
    logic             xl_exec = 1'b0;
    logic [1:0]       xl_ready, xl_err;
    logic [1:0][31:0] xl_pa;
    logic [1:0][1:0]  xl_cm, user_attribute_outputs;
    logic             mem_req, mem_we, mem_nocache, mem_ack, mem_terr;
    logic [31:0]      mem_addr, mem_wdata, mem_rdata;
    logic [1:0]       lat = 2'h0;
    logic [31:0]      terr_addr = 32'hFFFF_FFFF;
    logic [31:0]      seed = 32'h2A;
    logic [36:0]      notes [$];
    int               n_fail = 0;
    int               samples_checked = 0;
    localparam logic [36:0] ER = {1'b1, 36'h0};

    paged_address_translation_unit i_dut (.*);
    patu_mem_model i_mem (.*);

    // free running clock
    always #5 clk_sys = ~clk_sys;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [36:0] ex(input logic [31:0] f, la, input logic k8,
                                       input logic [1:0] cm, ua);
        return {1'b0, ua, cm, k8 ? {f[31:13], la[12:0]} : {f[31:12], la[11:0]}};
    endfunction

    task automatic chk_val(input logic [36:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // only the error flag counts on a refused access
    task automatic chk_res(input logic [36:0] got, exp);
        chk_val(exp[36] ? {got[36], 36'h0} : got, exp);
    endtask

    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // wait for the access edge, the watchdog ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // idle edge keeps the next setup out of this time step
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(a, 1'b1, d, rd, e);
    endtask

    // request held until ready, n is edges waited
    task automatic access(input int p, input logic [31:0] la, input logic su, w,
                          input logic [36:0] exp, output int n);
        notes.push_back(exp);
        lat         <= 2'(rnd());
        xl_req[p]   <= 1'b1;
        xl_la[p]    <= la;
        xl_super[p] <= su;
        xl_write[p] <= w;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (xl_ready[p] !== 1'b1 && n < 200);
        if (n >= 200) n_fail++;
        xl_req[p] <= 1'b0;
        // idle edge before the next request
        @(posedge clk_sys);
    endtask

    // three level tree: root slot, pointer table at t, page table at t+0x200
    task automatic mk(input logic [31:0] r, la, t, pd, pw, input logic k8,
                      output logic [31:0] pga);
        logic [31:0] d;
        d = t + 32'h200;
        i_mem.mem[{r[31:9], la[31:25], 2'b00}] = t | 32'hA;
        i_mem.mem[{t[31:9], la[24:18], 2'b00}] = d | 32'hA | pw;
        pga = k8 ? {d[31:7], la[17:13], 2'b00} : {d[31:8], la[17:12], 2'b00};
        i_mem.mem[pga] = pd;
    endtask

    task automatic fin(input string s);
        $display("test %s done", s);
    endtask

    task automatic summarize();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // result watcher and watchdog
    // ----------------------------------------
    always @(posedge clk_sys) begin
        logic [36:0] g;
        if (rst_b) begin
            for (int p = 0; p < 2; p++) begin
                g = {xl_err[p], user_attribute_outputs[p], xl_cm[p], xl_pa[p]};
                if (xl_req[p] && xl_ready[p] === 1'b1) chk_res(g, notes.pop_front());
            end
            if (mem_req) chk_val(37'(mem_nocache), 37'h1);
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        summarize();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] a, b, pg, rd;
        logic        e;
        int          n;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        a = rnd();
        access(1, a, 1'b1, 1'b0, ex(a, a, 0, 2'h0, 2'h0), n);
        wr(8'h00, 32'h39);
        translation_disable_in <= 1'b1;
        a = rnd();
        access(0, a, 1'b1, 1'b0, ex(a, a, 0, 2'h2, 2'h3), n);
        translation_disable_in <= 1'b0;
        fin("bypass");
        wr(8'h08, 32'h1000);
        wr(8'h04, 32'h8000);
        a = 32'h0200_5000 | (rnd() & 32'hFFF);
        mk(32'h1000, a, 32'h10000, 32'h0077_7141, 32'h0, 1'b0, pg);
        access(1, a, 1'b1, 1'b0, ex(32'h777000, a, 0, 2'h2, 2'h1), n);
        chk_val(37'(i_mem.mem[pg] & 32'h8), 37'h8);
        access(1, a, 1'b1, 1'b0, ex(32'h777000, a, 0, 2'h2, 2'h1), n);
        chk_val(37'(n), 37'h1);
        mk(32'h8000, a, 32'h20000, 32'h0055_5229, 32'h0, 1'b0, pg);
        access(1, a, 1'b0, 1'b0, ex(32'h555000, a, 0, 2'h1, 2'h2), n);
        fin("walk4k");
        a = 32'h0400_3000 | (rnd() & 32'hFFF);
        mk(32'h8000, a, 32'h30000, 32'h0099_9089, 32'h0, 1'b0, pg);
        access(1, a, 1'b0, 1'b0, ER, n);
        a = 32'h0600_1000 | (rnd() & 32'hFFF);
        mk(32'h1000, a, 32'h40000, 32'h00AA_A009, 32'h4, 1'b0, pg);
        access(1, a, 1'b1, 1'b0, ex(32'hAAA000, a, 0, 2'h0, 2'h0), n);
        access(1, a, 1'b1, 1'b1, ER, n);
        fin("protect");
        mk(32'h1000, 32'h0800_2000, 32'h50000, 32'h0, 32'h0, 1'b0, pg);
        access(1, 32'h0800_2000, 1'b1, 1'b0, ER, n);
        access(0, 32'h0800_2000, 1'b1, 1'b0, ER, n);
        @(posedge clk_sys);
        chk_val(37'(exec_err), 37'h0);
        xl_exec <= 1'b1;
        @(posedge clk_sys);
        chk_val(37'(exec_err), 37'h1);
        xl_exec <= 1'b0;
        i_mem.mem[32'h1014] = 32'h6000A;
        access(1, 32'h0A00_0000, 1'b1, 1'b0, ER, n);
        i_mem.mem[32'h1018] = 32'h7000A;
        terr_addr <= 32'h1018;
        access(1, 32'h0C00_0000, 1'b1, 1'b0, ER, n);
        terr_addr <= 32'hFFFF_FFFF;
        fin("faults");
        wr(8'h00, 32'h3);
        wr(8'h0C, 32'h1);
        a = 32'h0E00_4000 | (rnd() & 32'h1FFF);
        mk(32'h1000, a, 32'h60000, 32'h0007_0002, 32'h0, 1'b1, pg);
        i_mem.mem[32'h70000] = 32'h00BB_C569;
        access(1, a, 1'b1, 1'b0, ex(32'hBBC000, a, 1, 2'h3, 2'h1), n);
        b = 32'h1000_6000 | (rnd() & 32'h1FFF);
        mk(32'h1000, b, 32'h80000, 32'h00CC_E029, 32'h0, 1'b1, pg);
        access(1, b, 1'b1, 1'b0, ex(32'hCCE000, b, 1, 2'h1, 2'h0), n);
        wr(8'h0C, 32'h3);
        access(1, a, 1'b1, 1'b0, ex(32'hBBC000, a, 1, 2'h3, 2'h1), n);
        chk_val(37'(n), 37'h1);
        access(1, b, 1'b1, 1'b0, ex(32'hCCE000, b, 1, 2'h1, 2'h0), n);
        chk_val(37'(n > 1), 37'h1);
        fin("walk8k");
        wr(8'h28, 32'h4000_C260);
        a = 32'h4000_0000 | (rnd() & 32'h00FF_FFFF);
        access(1, a, 1'b0, 1'b1, ex(a, a, 0, 2'h3, 2'h2), n);
        chk_val(37'(n), 37'h1);
        apb(8'h08, 1'b0, 32'h0, rd, e);
        chk_val(37'(rd), 37'h1000);
        apb(8'h40, 1'b0, 32'h0, rd, e);
        chk_val(37'({e, rd}), 37'h1_0000_0000);
        fin("blocks");
        summarize();
    end
endmodule
`default_nettype wire

// file: dv/patu_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module patu_mem_model (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // descriptor bus
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic             mem_ack,
    output logic             mem_terr,
    output logic      [31:0] mem_rdata,
    // test control
    input  wire logic [1:0]  lat,
    input  wire logic [31:0] terr_addr
);
    logic [31:0] mem [logic [31:0]];
    logic [1:0]  wait_q;

    // answer after lat idle cycles, data scrambled between answers
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mem_ack   <= 1'b0;
            mem_terr  <= 1'b0;
            mem_rdata <= 32'h0;
            wait_q    <= 2'h0;
        end else if (mem_req && !mem_ack && wait_q == lat) begin
            mem_ack  <= 1'b1;
            mem_terr <= (mem_addr == terr_addr);
            wait_q   <= 2'h0;
            if (mem_we) begin
                mem[mem_addr] = mem_wdata; // history lands in memory
            end
            mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0;
        end else begin
            mem_ack   <= 1'b0;
            mem_terr  <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_q    <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
        end
    end
endmodule
`default_nettype wire
